// ===== core/pll_clock_synth_flags.sv
// Top of the PLL clock synthesizer: control registers, clock ratios, lock and flags.
// Assumes oscillator, internal reference and VCO arrive as one-cycle enable pulses,
// and that the register master keeps strobes one cycle long and never overlapping.
`default_nettype none
module pll_clock_synth_flags (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [clk_synth_pkg::ADDR_W-1:0] addr,
	input wire logic [clk_synth_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [clk_synth_pkg::DATA_W-1:0] rdata,
	input wire logic osc_tick,
	input wire logic irc_tick,
	input wire logic vco_tick,
	input wire logic periodic_timeout,
	input wire logic brownout_reset_event,
	input wire logic bad_address_reset_event,
	input wire logic sys_reset,
	input wire logic full_stop_entry,
	output logic ref_tick,
	output logic pll_tick,
	output logic bus_tick,
	output logic can_osc_tick,
	output logic [1:0] vco_range,
	output logic [1:0] pll_filter_range,
	output logic pll_locked,
	output logic osc_qualified,
	output logic ext_osc_enable,
	output logic pll_source_select,
	output logic periodic_irq,
	output logic pll_change_irq,
	output logic osc_change_irq
);
	import clk_synth_pkg::*;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n;

	// Two-stage release; assertion stays asynchronous
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	logic wr_syn;
	logic wr_ref_divider_field;
	logic wr_post_divider_field;
	logic wr_flags;
	logic wr_irq_en;
	logic wr_clk_sel;
	logic wr_osc_ctrl;
	logic wr_guard;
	logic pll_sel_r;
	logic guard_r;
	logic cfg_open;
	logic cfg_write;

	// Write strobes per register
	assign wr_syn = wr && hit(addr, OFF_SYN);
	assign wr_ref_divider_field = wr && hit(addr, OFF_REF_DIVIDER_FIELD);
	assign wr_post_divider_field = wr && hit(addr, OFF_POST_DIVIDER_FIELD);
	assign wr_flags = wr && hit(addr, OFF_FLAGS);
	assign wr_irq_en = wr && hit(addr, OFF_IRQ_EN);
	assign wr_clk_sel = wr && hit(addr, OFF_CLK_SEL);
	assign wr_osc_ctrl = wr && hit(addr, OFF_OSC_CTRL);
	assign wr_guard = wr && hit(addr, OFF_GUARD);

	assign cfg_open = !guard_r && pll_sel_r;
	// accepted multiplier write; accepted ref_divider_field write
	assign cfg_write = cfg_open && (wr_syn || wr_ref_divider_field);

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [DATA_W-1:0] syn_r;
	logic [DATA_W-1:0] ref_divider_field_r;
	logic [DATA_W-1:0] post_divider_field_r;
	logic [DATA_W-1:0] irq_en_r;
	logic pll_sel_nxt;
	logic osc_en_r;
	logic osc_q_r;

	// unqualified oscillator or full stop force PLL select
	assign pll_sel_nxt = (!osc_q_r || full_stop_entry) ? 1'b1 :
		((wr_clk_sel && !guard_r) ? wdata[BIT_PLL_SEL] : pll_sel_r);

	// Software-written configuration; system reset restores it, flags survive
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			syn_r <= SYN_RST;
			ref_divider_field_r <= REF_DIVIDER_FIELD_RST;
			post_divider_field_r <= POST_DIVIDER_FIELD_RST;
			irq_en_r <= IRQ_EN_RST;
			pll_sel_r <= PLL_SEL_RST;
			osc_en_r <= OSC_EN_RST;
			guard_r <= GUARD_RST;
		end else if (sys_reset) begin
			syn_r <= SYN_RST;
			ref_divider_field_r <= REF_DIVIDER_FIELD_RST;
			post_divider_field_r <= POST_DIVIDER_FIELD_RST;
			irq_en_r <= IRQ_EN_RST;
			pll_sel_r <= PLL_SEL_RST;
			osc_en_r <= OSC_EN_RST;
			guard_r <= GUARD_RST;
		end else begin
			if (wr_syn && cfg_open) syn_r <= wdata;
			if (wr_ref_divider_field && cfg_open) ref_divider_field_r <= wdata;
			if (wr_post_divider_field && pll_sel_r) post_divider_field_r <= wdata;
			// enables at bits 7, 4, 1
			if (wr_irq_en) irq_en_r <= wdata & IRQ_EN_MASK;
			if (wr_osc_ctrl) osc_en_r <= wdata[BIT_OSC_EN];
			if (wr_guard) guard_r <= wdata[BIT_GUARD];
			pll_sel_r <= pll_sel_nxt;
		end
	end

	// ------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------
	logic [MULT_W-1:0] mult;
	logic [REF_DIVIDER_FIELD_W-1:0] ref_divider_field;
	logic [POST_DIVIDER_FIELD_W-1:0] post_divider_field;
	logic [1:0] ref_range;
	logic [CNT_W-1:0] lock_target;

	assign mult = syn_r[MULT_W-1:0];
	assign ref_divider_field = ref_divider_field_r[REF_DIVIDER_FIELD_W-1:0];
	assign post_divider_field = post_divider_field_r[POST_DIVIDER_FIELD_W-1:0];
	assign ref_range = ref_divider_field_r[RANGE_LSB+1:RANGE_LSB];
	// target is 2 x (multiplier + 1) VCO pulses per reference
	assign lock_target = {({1'b0, mult} + 7'h01), 1'b0};

	// ------------------------------------------------------------
	// Dividers and lock monitor
	// ------------------------------------------------------------
	div_if ref_dv();
	div_if post_dv();
	div_if bus_dv();
	lock_if lk();
	logic locked;

	assign ref_dv.tick_in = osc_en_r ? osc_tick : irc_tick;
	assign ref_dv.ratio = osc_en_r ? {{(DIV_W-REF_DIVIDER_FIELD_W){1'b0}}, ref_divider_field} : '0;
	assign ref_dv.restart = cfg_write;

	// post divide while locked, safe divide-by-4 otherwise
	assign post_dv.tick_in = vco_tick;
	assign post_dv.ratio = locked ? {{(DIV_W-POST_DIVIDER_FIELD_W){1'b0}}, post_divider_field} : UNLOCKED_RATIO;
	assign post_dv.restart = cfg_write;

	// bus runs at half the selected source
	assign bus_dv.tick_in = pll_sel_r ? post_dv.tick_out : osc_tick;
	assign bus_dv.ratio = BUS_RATIO;
	assign bus_dv.restart = 1'b0;

	// restart lock on accepted config write
	assign lk.ref_tick = ref_dv.tick_out;
	assign lk.vco_tick = vco_tick;
	assign lk.restart = cfg_write;
	assign lk.target = lock_target;
	assign locked = lk.locked;

	tick_divider u_ref_div (
		.clock(clock),
		.rst_n(rst_n),
		.dv(ref_dv)
	);

	tick_divider u_post_div (
		.clock(clock),
		.rst_n(rst_n),
		.dv(post_dv)
	);

	tick_divider u_bus_div (
		.clock(clock),
		.rst_n(rst_n),
		.dv(bus_dv)
	);

	lock_monitor u_lock (
		.clock(clock),
		.rst_n(rst_n),
		.lk(lk)
	);

	// ------------------------------------------------------------
	// Oscillator qualification
	// ------------------------------------------------------------
	logic [3:0] qual_cnt_r;
	logic qual_drop;

	// Qualification relies on the VCO, so losing lock loses it too
	assign qual_drop = cfg_write || full_stop_entry || !locked || !osc_en_r;

	// qualified after enough locked windows, cleared on stop
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			qual_cnt_r <= '0;
			osc_q_r <= 1'b0;
		end else if (qual_drop) begin
			qual_cnt_r <= '0;
			osc_q_r <= 1'b0;
		end else if (ref_dv.tick_out && !osc_q_r) begin
			qual_cnt_r <= qual_cnt_r + 4'h1;
			if (qual_cnt_r == OSC_QUAL_WINDOWS - 4'h1) osc_q_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------
	logic [DATA_W-1:0] flags_r;
	logic [DATA_W-1:0] flags_set;
	logic [DATA_W-1:0] flags_clr;
	logic lock_d_r;
	logic osc_q_d_r;
	logic lock_change;
	logic osc_change;

	// lock change either way; qualification change
	assign lock_change = locked ^ lock_d_r;
	assign osc_change = osc_q_r ^ osc_q_d_r;
	assign flags_set = {periodic_timeout, 1'b0, brownout_reset_event, lock_change,
		1'b0, bad_address_reset_event, osc_change, 1'b0};
	// writing 1 clears, writing 0 does nothing
	assign flags_clr = wr_flags ? (wdata & FLAGS_W1C_MASK) : '0;

	// Sticky flags; only power-on reset touches them
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= FLAGS_POR;
			lock_d_r <= 1'b0;
			osc_q_d_r <= 1'b0;
		end else begin
			flags_r <= (flags_r & ~flags_clr) | flags_set;
			lock_d_r <= locked;
			osc_q_d_r <= osc_q_r;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [DATA_W-1:0] flags_view;
	logic [DATA_W-1:0] rd_mux;
	logic [DATA_W-1:0] rdata_r;

	// lock status live; qualification live, both read-only
	always_comb begin
		flags_view = flags_r & FLAGS_W1C_MASK;
		flags_view[BIT_LOCK] = locked;
		flags_view[BIT_OSC_Q] = osc_q_r;
	end

	// Unmapped addresses read as zero
	assign rd_mux = hit(addr, OFF_SYN) ? syn_r :
		hit(addr, OFF_REF_DIVIDER_FIELD) ? ref_divider_field_r :
		hit(addr, OFF_POST_DIVIDER_FIELD) ? post_divider_field_r :
		hit(addr, OFF_FLAGS) ? flags_view :
		hit(addr, OFF_IRQ_EN) ? irq_en_r :
		hit(addr, OFF_CLK_SEL) ? {pll_sel_r, 7'h00} :
		hit(addr, OFF_OSC_CTRL) ? {osc_en_r, 7'h00} :
		hit(addr, OFF_GUARD) ? {7'h00, guard_r} : 8'h00;

	// Data valid only in the cycle after the read strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) rdata_r <= '0;
		else rdata_r <= rd ? rd_mux : '0;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic can_osc_r;
	logic [1:0] filter_r;

	// CAN oscillator clock gated while unqualified
	// internal reference pins the filter to the lowest range
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			can_osc_r <= 1'b0;
			filter_r <= FILTER_LOW_RANGE;
		end else begin
			can_osc_r <= osc_tick && osc_q_r;
			filter_r <= osc_en_r ? ref_range : FILTER_LOW_RANGE;
		end
	end

	assign rdata = rdata_r;
	assign ref_tick = ref_dv.tick_out;
	assign pll_tick = post_dv.tick_out;
	assign bus_tick = bus_dv.tick_out;
	assign can_osc_tick = can_osc_r;
	// Range code passed to the analog VCO as written; reserved codes unchecked
	assign vco_range = syn_r[RANGE_LSB+1:RANGE_LSB];
	assign pll_filter_range = filter_r;
	assign pll_locked = locked;
	assign osc_qualified = osc_q_r;
	assign ext_osc_enable = osc_en_r;
	assign pll_source_select = pll_sel_r;
	assign periodic_irq = flags_r[BIT_PERIODIC] && irq_en_r[BIT_PERIODIC];
	assign pll_change_irq = flags_r[BIT_PLL_CHG] && irq_en_r[BIT_PLL_CHG];
	assign osc_change_irq = flags_r[BIT_OSC_CHG] && irq_en_r[BIT_OSC_CHG];
endmodule
`default_nettype wire

// ===== inc/clk_synth_pkg.sv
// Constants, field layout and lock-monitor states for the PLL clock synthesizer block.
// Assumes one 50 MHz clock; every slower rate is carried as a one-cycle enable pulse.
`default_nettype none
package clk_synth_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int DIV_W = 6;
	localparam int CNT_W = 8;
	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_SYN = 10'h034;
	localparam logic [ADDR_W-1:0] OFF_REF_DIVIDER_FIELD = 10'h035;
	localparam logic [ADDR_W-1:0] OFF_POST_DIVIDER_FIELD = 10'h036;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 10'h037;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 10'h038;
	localparam logic [ADDR_W-1:0] OFF_CLK_SEL = 10'h039;
	localparam logic [ADDR_W-1:0] OFF_OSC_CTRL = 10'h2fa;
	localparam logic [ADDR_W-1:0] OFF_GUARD = 10'h2fb;
	// Field positions
	localparam int BIT_PERIODIC = 7;
	localparam int BIT_POWER_ON_FLAG = 6;
	localparam int BIT_BROWNOUT = 5;
	localparam int BIT_PLL_CHG = 4;
	localparam int BIT_LOCK = 3;
	localparam int BIT_BAD_ADDR = 2;
	localparam int BIT_OSC_CHG = 1;
	localparam int BIT_OSC_Q = 0;
	localparam int BIT_PLL_SEL = 7;
	localparam int BIT_OSC_EN = 7;
	localparam int BIT_GUARD = 0;
	localparam int MULT_W = 6;
	localparam int RANGE_LSB = 6;
	localparam int REF_DIVIDER_FIELD_W = 4;
	localparam int POST_DIVIDER_FIELD_W = 5;
	// Reset values
	localparam logic [DATA_W-1:0] SYN_RST = 8'h00;
	localparam logic [DATA_W-1:0] REF_DIVIDER_FIELD_RST = 8'h00;
	localparam logic [DATA_W-1:0] POST_DIVIDER_FIELD_RST = 8'h00;
	localparam logic [DATA_W-1:0] IRQ_EN_RST = 8'h00;
	localparam logic [DATA_W-1:0] FLAGS_POR = 8'h60;
	localparam logic [DATA_W-1:0] FLAGS_W1C_MASK = 8'hf6;
	localparam logic [DATA_W-1:0] IRQ_EN_MASK = 8'h92;
	localparam logic PLL_SEL_RST = 1'b1;
	localparam logic OSC_EN_RST = 1'b0;
	localparam logic GUARD_RST = 1'b0;
	// Timing counts, in reference windows or ticks
	localparam logic [DIV_W-1:0] UNLOCKED_RATIO = 6'h03;
	localparam logic [DIV_W-1:0] BUS_RATIO = 6'h01;
	localparam logic [CNT_W-1:0] LOCK_TOL = 8'h02;
	localparam logic [2:0] LOCK_GOOD_WINDOWS = 3'h4;
	localparam logic [3:0] OSC_QUAL_WINDOWS = 4'h8;
	localparam logic [1:0] FILTER_LOW_RANGE = 2'h0;
	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_CHECK = 2'b01,
		LK_LOCKED = 2'b11
	} lock_state_t;
endpackage
`default_nettype wire

// ===== inc/clk_synth_if.sv
// Carriers between the synthesizer top and its divider and lock-monitor leaves.
// Assumes the owner drives all inputs from its single clock domain.
`default_nettype none
interface div_if;
	import clk_synth_pkg::*;
	logic tick_in;
	logic [DIV_W-1:0] ratio;
	logic restart;
	logic tick_out;
	modport owner(output tick_in, ratio, restart, input tick_out);
	modport divider(input tick_in, ratio, restart, output tick_out);
endinterface

interface lock_if;
	import clk_synth_pkg::*;
	logic ref_tick;
	logic vco_tick;
	logic restart;
	logic [CNT_W-1:0] target;
	logic locked;
	modport owner(output ref_tick, vco_tick, restart, target, input locked);
	modport monitor(input ref_tick, vco_tick, restart, target, output locked);
endinterface
`default_nettype wire

// ===== core/tick_divider.sv
// Enable-pulse divider: one output pulse per ratio+1 input pulses.
// Assumes an active-low reset whose release is already synchronous.
`default_nettype none
module tick_divider (
	input wire logic clock,
	input wire logic rst_n,
	div_if.divider dv
);
	import clk_synth_pkg::*;
	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] cnt_nxt;
	logic out_r;
	logic at_end;

	// Greater-or-equal so a ratio lowered mid-count cannot run away
	assign at_end = (cnt_r >= dv.ratio);
	assign cnt_nxt = dv.restart ? '0 : (!dv.tick_in ? cnt_r : (at_end ? '0 : cnt_r + 1'b1));
	assign dv.tick_out = out_r;

	// Counter and registered pulse
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			out_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			out_r <= !dv.restart && dv.tick_in && at_end;
		end
	end
endmodule
`default_nettype wire

// ===== core/lock_monitor.sv
// Counts VCO pulses in each reference window and judges lock against a target.
// Assumes ref and vco ticks are one-cycle pulses on the system clock.
`default_nettype none
module lock_monitor (
	input wire logic clock,
	input wire logic rst_n,
	lock_if.monitor lk
);
	import clk_synth_pkg::*;
	lock_state_t state_r, state_nxt;
	logic [CNT_W-1:0] vco_cnt_r;
	logic [2:0] good_r;
	logic [CNT_W:0] cnt_hi;
	logic [CNT_W:0] tgt_hi;
	logic in_tol;
	logic sat;

	// Tolerance window compare, one bit wider to avoid wrap
	assign cnt_hi = {1'b0, vco_cnt_r} + {1'b0, LOCK_TOL};
	assign tgt_hi = {1'b0, lk.target} + {1'b0, LOCK_TOL};
	assign in_tol = (cnt_hi >= {1'b0, lk.target}) && ({1'b0, vco_cnt_r} <= tgt_hi);
	assign sat = &vco_cnt_r;
	assign lk.locked = (state_r == LK_LOCKED);

	// Next state: one bad window drops lock, several good ones gain it
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			LK_IDLE: if (lk.ref_tick) state_nxt = LK_CHECK;
			LK_CHECK: if (lk.ref_tick && in_tol && good_r == LOCK_GOOD_WINDOWS - 3'h1)
				state_nxt = LK_LOCKED;
			LK_LOCKED: if (lk.ref_tick && !in_tol) state_nxt = LK_CHECK;
			default: state_nxt = LK_IDLE;
		endcase
		if (lk.restart) state_nxt = LK_IDLE;
	end

	// Window counter and good-window run
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= LK_IDLE;
			vco_cnt_r <= '0;
			good_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (lk.restart || lk.ref_tick) vco_cnt_r <= {{(CNT_W-1){1'b0}}, lk.vco_tick};
			else if (lk.vco_tick && !sat) vco_cnt_r <= vco_cnt_r + 1'b1;
			if (lk.restart || (lk.ref_tick && (!in_tol || state_r != LK_CHECK))) good_r <= '0;
			else if (lk.ref_tick) good_r <= good_r + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ===== bench/pll_clock_synth_flags_properties.sv
// Checker for the synthesizer top: flag, irq, lock restart and gating relations.
// Assumes it is bound to the top and sees only its ports.
`default_nettype none
module pll_clock_synth_flags_properties (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [clk_synth_pkg::ADDR_W-1:0] addr,
	input wire logic [clk_synth_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic periodic_timeout,
	input wire logic sys_reset,
	input wire logic full_stop_entry,
	input wire logic can_osc_tick,
	input wire logic [1:0] pll_filter_range,
	input wire logic pll_locked,
	input wire logic osc_qualified,
	input wire logic ext_osc_enable,
	input wire logic pll_source_select,
	input wire logic periodic_irq,
	input wire logic pll_change_irq,
	input wire logic osc_change_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	import clk_synth_pkg::*;
	// ----
	// Properties
	// ----
	logic guard_r;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	// Guard copy, so a refused write is not mistaken for a restart
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			guard_r <= GUARD_RST;
		else if (sys_reset)
			guard_r <= GUARD_RST;
		else if (wr && addr == OFF_GUARD)
			guard_r <= wdata[BIT_GUARD];
	end
	irq_set_cause_a: assert property (
		$rose(periodic_irq) |-> $past(periodic_timeout) || $past(wr))
		else $error("periodic irq rose without a cause");
	irq_sticky_a: assert property (
		periodic_irq && !wr && !sys_reset |=> periodic_irq)
		else $error("periodic irq dropped without a write");
	lock_chg_cause_a: assert property (
		$rose(pll_change_irq) |-> $past(pll_locked) != $past(pll_locked, 2) || $past(wr))
		else $error("lock change irq without a lock change");
	osc_chg_cause_a: assert property (
		$rose(osc_change_irq) |-> $past(osc_qualified) != $past(osc_qualified, 2) || $past(wr))
		else $error("osc change irq without a status change");
	filter_fixed_a: assert property (
		!ext_osc_enable && !$past(ext_osc_enable) |-> pll_filter_range == FILTER_LOW_RANGE)
		else $error("filter range moved on internal reference");
	can_gated_a: assert property (
		!osc_qualified && !$past(osc_qualified) |-> !can_osc_tick)
		else $error("can clock ran while oscillator unqualified");
	sel_forced_a: assert property (
		!osc_qualified && !$past(osc_qualified) |-> pll_source_select)
		else $error("pll select clear while oscillator unqualified");
	stop_entry_a: assert property (
		full_stop_entry |=> !osc_qualified && pll_source_select)
		else $error("full stop did not drop qualification");
	div_restart_a: assert property (
		wr && (addr == OFF_SYN || addr == OFF_REF_DIVIDER_FIELD) && !guard_r && pll_source_select
		|=> !pll_locked && !osc_qualified) else $error("divider write kept lock");
	qual_locked_a: assert property (
		$rose(osc_qualified) |-> $past(pll_locked))
		else $error("oscillator qualified without lock");
	// Main scenarios reached
	cover property ($rose(pll_locked));
	cover property ($rose(osc_qualified));
	cover property (full_stop_entry && osc_qualified);
endmodule
`default_nettype wire

// ===== bench/pll_clock_synth_flags_tb.sv
// Self-checking bench for the synthesizer top: registers, flags, lock, ratios.
// Assumes the package and design files are compiled first.
`default_nettype none
module pll_clock_synth_flags_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import clk_synth_pkg::*;
	// ----
	// Stimulus and checks
	// ----
	typedef struct {logic [ADDR_W-1:0] a; logic [7:0] d; logic [7:0] q;} row_t;
	logic clock = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
	logic osc_tick = 1'b0, irc_tick = 1'b0, vco_tick = 1'b0, sys_reset = 1'b0;
	logic periodic_timeout = 1'b0, brownout_reset_event = 1'b0;
	logic bad_address_reset_event = 1'b0, full_stop_entry = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [7:0] wdata = 8'h00, rdata;
	logic ref_tick, pll_tick, bus_tick, can_osc_tick, pll_locked, osc_qualified;
	logic ext_osc_enable, pll_source_select, periodic_irq, pll_change_irq, osc_change_irq;
	logic [1:0] vco_range, pll_filter_range;
	int miscompares = 0, checked = 0, phase = 0, p, b, c, r;
	// Unmapped last-but-one; multiplier last so lock starts right before measuring
	row_t rows [5] = '{'{OFF_IRQ_EN, 8'hff, 8'h92}, '{OFF_POST_DIVIDER_FIELD, 8'h01, 8'h01},
		'{OFF_REF_DIVIDER_FIELD, 8'hc1, 8'hc1}, '{10'h3ff, 8'haa, 8'h00}, '{OFF_SYN, 8'h44, 8'h44}};
	pll_clock_synth_flags pll_clock_synth_flags_inst (.clock(clock), .resetn(resetn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_tick(osc_tick),
		.irc_tick(irc_tick), .vco_tick(vco_tick), .periodic_timeout(periodic_timeout),
		.brownout_reset_event(brownout_reset_event), .sys_reset(sys_reset),
		.bad_address_reset_event(bad_address_reset_event), .full_stop_entry(full_stop_entry),
		.ref_tick(ref_tick), .pll_tick(pll_tick), .bus_tick(bus_tick),
		.can_osc_tick(can_osc_tick), .vco_range(vco_range), .pll_filter_range(pll_filter_range),
		.pll_locked(pll_locked), .osc_qualified(osc_qualified), .ext_osc_enable(ext_osc_enable),
		.pll_source_select(pll_source_select), .periodic_irq(periodic_irq),
		.pll_change_irq(pll_change_irq), .osc_change_irq(osc_change_irq));
	// 50 MHz clock
	initial forever #10 clock = ~clock;
	// VCO every 5, oscillator every 25, internal ref every 50 cycles: 10 VCO per window
	always @(posedge clock) begin
		phase <= phase + 1;
		vco_tick <= (phase % 5) == 0;
		osc_tick <= (phase % 25) == 0;
		irc_tick <= (phase % 50) == 0;
	end
	task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Tick counts may shift by one with window phase
	task automatic cmp_near(input string name, input int exp, input int got);
		checked++;
		if (got > exp + 1 || got < exp - 1) begin
			miscompares++;
			$display("MISMATCH %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] q);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		cmp($sformatf("reg %h", a), q, rdata);
	endtask
	task automatic measure(input int n, output int pt, output int bt, output int ct,
		output int rt);
		pt = 0;
		bt = 0;
		ct = 0;
		rt = 0;
		repeat (n) begin
			@(posedge clock);
			#1;
			rt += int'(ref_tick);
			pt += int'(pll_tick);
			bt += int'(bus_tick);
			ct += int'(can_osc_tick);
		end
	endtask
	task automatic wait_high(input string name, input int sel);
		int k;
		for (k = 0; k < 3000; k++) begin
			@(posedge clock);
			#1;
			if ((sel == 0 ? pll_locked : osc_qualified) === 1'b1)
				break;
		end
		if (k == 3000) begin
			miscompares++;
			$display("MISMATCH %s expected 1 seen 0", name);
			tally_and_finish();
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		#1;
		cmp("sel at reset", 8'h01, pll_source_select);
		rd_chk(OFF_FLAGS, 8'h60);
		wr_reg(OFF_FLAGS, 8'h00);
		rd_chk(OFF_FLAGS, 8'h60);
		wr_reg(OFF_FLAGS, 8'h60);
		rd_chk(OFF_FLAGS, 8'h00);
		wr_reg(OFF_IRQ_EN, 8'h80);
		@(posedge clock);
		periodic_timeout <= 1'b1;
		brownout_reset_event <= 1'b1;
		bad_address_reset_event <= 1'b1;
		@(posedge clock);
		periodic_timeout <= 1'b0;
		brownout_reset_event <= 1'b0;
		bad_address_reset_event <= 1'b0;
		rd_chk(OFF_FLAGS, 8'ha4);
		cmp("periodic irq", 8'h01, periodic_irq);
		// Set and write-one clear in one cycle: the set must hold the flag
		@(posedge clock);
		periodic_timeout <= 1'b1;
		addr <= OFF_FLAGS;
		wdata <= 8'h80;
		wr <= 1'b1;
		@(posedge clock);
		periodic_timeout <= 1'b0;
		wr <= 1'b0;
		rd_chk(OFF_FLAGS, 8'ha4);
		@(posedge clock);
		sys_reset <= 1'b1;
		@(posedge clock);
		sys_reset <= 1'b0;
		rd_chk(OFF_FLAGS, 8'ha4);
		cmp("irq after sys reset", 8'h00, periodic_irq);
		wr_reg(OFF_FLAGS, 8'hff);
		rd_chk(OFF_FLAGS, 8'h00);
		foreach (rows[i]) begin
			wr_reg(rows[i].a, rows[i].d);
			rd_chk(rows[i].a, rows[i].q);
		end
		cmp("vco range", 8'h01, vco_range);
		cmp("filter internal", 8'h00, pll_filter_range);
		measure(150, p, b, c, r);
		cmp_near("ref internal", 150 / 50, r);
		cmp_near("pll unlocked", 150 / 5 / 4, p);
		cmp_near("bus unlocked", 150 / 5 / 8, b);
		wait_high("locked", 0);
		rd_chk(OFF_FLAGS, 8'h18);
		cmp("lock irq", 8'h01, pll_change_irq);
		measure(200, p, b, c, r);
		cmp_near("pll locked", 200 / 5 / 2, p);
		cmp_near("bus locked", 200 / 5 / 4, b);
		wr_reg(OFF_GUARD, 8'h01);
		wr_reg(OFF_SYN, 8'h00);
		rd_chk(OFF_SYN, 8'h44);
		cmp("still locked", 8'h01, pll_locked);
		wr_reg(OFF_POST_DIVIDER_FIELD, 8'h03);
		rd_chk(OFF_POST_DIVIDER_FIELD, 8'h03);
		wr_reg(OFF_GUARD, 8'h00);
		wr_reg(OFF_FLAGS, 8'h10);
		wr_reg(OFF_OSC_CTRL, 8'h80);
		#1;
		cmp("osc enable", 8'h01, ext_osc_enable);
		wr_reg(OFF_REF_DIVIDER_FIELD, 8'h81);
		#1;
		cmp("lock after ref_divider_field", 8'h00, pll_locked);
		rd_chk(OFF_FLAGS, 8'h10);
		cmp("filter external", 8'h02, pll_filter_range);
		wait_high("qualified", 1);
		rd_chk(OFF_FLAGS, 8'h1b);
		cmp("osc irq", 8'h01, osc_change_irq);
		measure(100, p, b, c, r);
		cmp_near("ref external", 100 / 50, r);
		cmp_near("can clock", 100 / 25, c);
		wr_reg(OFF_CLK_SEL, 8'h00);
		#1;
		cmp("sel cleared", 8'h00, pll_source_select);
		wr_reg(OFF_POST_DIVIDER_FIELD, 8'h07);
		rd_chk(OFF_POST_DIVIDER_FIELD, 8'h03);
		@(posedge clock);
		full_stop_entry <= 1'b1;
		@(posedge clock);
		full_stop_entry <= 1'b0;
		#1;
		cmp("stop osc", 8'h00, osc_qualified);
		cmp("stop sel", 8'h01, pll_source_select);
		// Bad address flag raised, then a power-on reset mid-run must clear it
		@(posedge clock);
		bad_address_reset_event <= 1'b1;
		@(posedge clock);
		bad_address_reset_event <= 1'b0;
		rd_chk(OFF_FLAGS, 8'h1e);
		resetn <= 1'b0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		rd_chk(OFF_FLAGS, 8'h60);
		tally_and_finish();
	end
endmodule
bind pll_clock_synth_flags pll_clock_synth_flags_properties pll_clock_synth_flags_properties_inst (
	.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
	.periodic_timeout(periodic_timeout), .sys_reset(sys_reset),
	.full_stop_entry(full_stop_entry), .can_osc_tick(can_osc_tick),
	.pll_filter_range(pll_filter_range), .pll_locked(pll_locked),
	.osc_qualified(osc_qualified), .ext_osc_enable(ext_osc_enable),
	.pll_source_select(pll_source_select), .periodic_irq(periodic_irq),
	.pll_change_irq(pll_change_irq), .osc_change_irq(osc_change_irq));
`default_nettype wire
